// ---- hw/tpc_map.svh ----
// register-free constants, field codes and timing counts for the channel control block
`ifndef TPC_MAP_SVH
`define TPC_MAP_SVH
`define TPC_PWR_P0        2'h0
`define TPC_PWR_P0S       2'h1
`define TPC_PWR_P1        2'h2
`define TPC_PWR_P2        2'h3
`define TPC_ST_OK         3'h0
`define TPC_ST_SKP_ADD    3'h1
`define TPC_ST_SKP_DEL    3'h2
`define TPC_ST_RX_DET     3'h3
`define TPC_ST_DEC_ERR    3'h4
`define TPC_ST_OVFL       3'h5
`define TPC_ST_UNFL       3'h6
`define TPC_ST_DISP_ERR   3'h7
`define TPC_SLIP_MAX      4'h9
`define TPC_MIN_RST_CYC   2
`define TPC_PRBS_ERR_CYC  3'h3
`define TPC_CLK_MHZ       200
`define TPC_FIXED_MHZ     125
`define TPC_DET_TIME_US   1
`define TPC_PLL_LOCK_US   10
`endif

// ---- hw/tpc_pkg.sv ----
// types shared by the channel control block
package tpc_pkg;
  typedef enum logic [1:0] {TPC_LOCK_AUTO = 2'h0, TPC_LOCK_REF = 2'h1, TPC_LOCK_DATA = 2'h2}
    tpc_lock_t;
  typedef enum logic [3:0]
  {
    TPC_DET_IDLE = 4'h1,
    TPC_DET_RUN  = 4'h2,
    TPC_DET_DONE = 4'h4,
    TPC_DET_WAIT = 4'h8
  } tpc_det_t;
endpackage

// ---- hw/tpc_sync.sv ----
// two-flop synchroniser for a bundle of asynchronous levels
`timescale 1ns/1ps
module tpc_sync #(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  typedef struct packed
  {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } tpc_sync_st_t;
  tpc_sync_st_t s_r;
  tpc_sync_st_t s_nxt;
  initial
  begin
    if (W < 1) $error("tpc_sync: width must be at least one");
  end
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.meta = async_in;
    s_nxt.sync = s_r.meta;
  end
  always_ff @(posedge clock)
  begin
    if (reset)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end
  assign sync_out = s_r.sync;
endmodule // tpc_sync

// ---- hw/tpc_ctrl.sv ----
// control and status logic around one serial transceiver channel
`timescale 1ns/1ps
`include "tpc_map.svh"
module tpc_ctrl
  import tpc_pkg::*;
#(
  parameter int PLL_LOCK_CYC = (`TPC_PLL_LOCK_US * `TPC_CLK_MHZ),
  parameter int DET_CYC      = (`TPC_DET_TIME_US * `TPC_CLK_MHZ)
) (
  input  wire logic       clock,
  input  wire logic       reset,
  input  wire logic       power_down,
  input  wire logic       pll_reset,
  input  wire logic       tx_digital_reset,
  input  wire logic       rx_digital_reset,
  input  wire logic       rx_analog_reset,
  input  wire logic       force_lock_data,
  input  wire logic       force_lock_ref,
  input  wire logic       cdr_freq_ok,
  input  wire logic [1:0] power_state,
  input  wire logic       force_elec_idle,
  input  wire logic       detect_loop,
  input  wire logic       far_receiver_present,
  input  wire logic       compliance_negdisp_force,
  input  wire logic       decoder_input_invert,
  input  wire logic [9:0] rx_word_in,
  input  wire logic       rx_word_valid,
  input  wire logic       rx_fifo_full,
  input  wire logic       rx_fifo_empty,
  input  wire logic       manual_align,
  input  wire logic       slip_request,
  input  wire logic       above_threshold,
  input  wire logic       sigdet_enable,
  input  wire logic       idle_infer_enable,
  input  wire logic       idle_inferred,
  input  wire logic       skip_added,
  input  wire logic       skip_removed,
  input  wire logic       decode_error,
  input  wire logic       buf_overflow,
  input  wire logic       buf_underflow,
  input  wire logic       disparity_error,
  input  wire logic       bist_mode,
  input  wire logic       prbs_mode,
  input  wire logic       pattern_cycle_done,
  input  wire logic       pattern_error,
  output logic [9:0]      decoder_word,
  output logic            encoder_negdisp,
  output logic            rx_fifo_error,
  output logic [3:0]      aligner_slip_count,
  output logic            lock_to_data_state,
  output logic            lock_to_reference_state,
  output logic            signal_detect,
  output logic            reverse_loopback,
  output logic            rx_valid,
  output logic            phy_done,
  output logic            elec_idle,
  output logic [2:0]      rx_status,
  output logic            pll_in_reset,
  output logic            pll_locked,
  output logic            tx_pcs_in_reset,
  output logic            rx_pcs_in_reset,
  output logic            rx_pma_in_reset,
  output logic            verifier_done,
  output logic            verifier_error
);
  localparam int NS = 12;
  typedef struct packed
  {
    tpc_det_t    det;
    logic [15:0] det_cnt;
    logic [15:0] pll_cnt;
    logic        pll_lock;
    logic [1:0]  pwr_prev;
    logic        done;
    logic [3:0]  slip;
    logic        slip_prev;
    logic [9:0]  word;
    logic        valid;
    logic [2:0]  status;
    logic        idle;
    logic        sigdet;
    logic        fifo_err;
    logic        loopback;
    logic        negdisp;
    logic        bdone;
    logic        berr;
    logic [2:0]  berr_cnt;
    logic        ltd;
    logic        done_hold;
  } tpc_state_t;
  tpc_state_t s_r;
  tpc_state_t s_nxt;
  logic [NS-1:0] raw;
  logic [NS-1:0] syn;
  logic          pd_s;
  logic          pllr_s;
  logic          rxd_s;
  logic          lkd_s;
  logic          lkr_s;
  logic [1:0]    pwr_s;
  logic          fei_s;
  logic          det_s;
  logic          cmp_s;
  logic          inv_s;
  logic          slip_s;
  tpc_lock_t     lock_mode;
  logic          in_data;
  logic          done_ev;
  initial
  begin
    if (`TPC_PRBS_ERR_CYC < 1) $error("tpc_ctrl: prbs error hold must be at least one cycle");
    if (PLL_LOCK_CYC < 1 || PLL_LOCK_CYC > 65535) $error("tpc_ctrl: bad pll lock count");
    if (DET_CYC < 1 || DET_CYC > 65535) $error("tpc_ctrl: bad detect count");
  end
  // decodes the two force inputs into a lock mode
  function automatic tpc_lock_t lock_decode(input logic fdata, input logic fref);
    if (fdata)
      return TPC_LOCK_DATA;
    else if (fref)
      return TPC_LOCK_REF;
    else
      return TPC_LOCK_AUTO;
  endfunction
  // saturating step of a 16-bit count
  function automatic logic [15:0] count_up(input logic [15:0] c, input int lim);
    if (int'(c) >= lim)
      return c;
    else
      return c + 16'h1;
  endfunction
  assign raw = {power_down, pll_reset, rx_digital_reset, force_lock_data, force_lock_ref,
                power_state, force_elec_idle, detect_loop, compliance_negdisp_force,
                decoder_input_invert, slip_request};
  tpc_sync #(
    .W (NS)
  ) u_sync (
    .clock    (clock),
    .reset    (reset),
    .async_in (raw),
    .sync_out (syn)
  );
  // bits of one bundle such as power_state land together only if they change together
  assign {pd_s, pllr_s, rxd_s, lkd_s, lkr_s,
          pwr_s, fei_s, det_s,
          cmp_s, inv_s, slip_s} = syn;
  assign lock_mode = lock_decode(lkd_s, lkr_s);
  always_comb
  begin
    unique case (lock_mode)
      TPC_LOCK_DATA: in_data = 1'b1;
      TPC_LOCK_REF:  in_data = 1'b0;
      TPC_LOCK_AUTO: in_data = cdr_freq_ok & s_r.pll_lock;
      default:       in_data = 1'b0;
    endcase
    if (pd_s || rx_analog_reset)
      in_data = 1'b0;
  end
  always_comb
  begin
    s_nxt      = s_r;
    s_nxt.done = 1'b0;
    s_nxt.pwr_prev = pwr_s;
    s_nxt.slip_prev = slip_s;
    // pll lock counter restarts on reset or power-down
    if (pllr_s || pd_s)
    begin
      s_nxt.pll_cnt  = '0;
      s_nxt.pll_lock = 1'b0;
    end
    else
    begin
      s_nxt.pll_cnt  = count_up(s_r.pll_cnt, PLL_LOCK_CYC);
      s_nxt.pll_lock = (int'(s_r.pll_cnt) >= PLL_LOCK_CYC - 1);
    end
    // power-state change completes in one cycle after it is seen
    if (pwr_s != s_r.pwr_prev)
      s_nxt.done = 1'b1;
    s_nxt.loopback = (pwr_s == `TPC_PWR_P0) && !fei_s && det_s;
    // registered so both lock-state outputs move on the same edge
    s_nxt.ltd      = in_data;
    unique case (s_r.det)
      TPC_DET_IDLE:
        if (det_s && fei_s && pwr_s == `TPC_PWR_P1)
        begin
          s_nxt.det     = TPC_DET_RUN;
          s_nxt.det_cnt = '0;
        end
      TPC_DET_RUN:
        if (int'(s_r.det_cnt) >= DET_CYC - 1)
          s_nxt.det = TPC_DET_DONE;
        else
          s_nxt.det_cnt = count_up(s_r.det_cnt, DET_CYC);
      TPC_DET_DONE:
      begin
        s_nxt.done = 1'b1;
        s_nxt.det  = TPC_DET_WAIT;
      end
      TPC_DET_WAIT:
        // controller must drop the request before another detection may start
        if (!det_s)
          s_nxt.det = TPC_DET_IDLE;
      default: s_nxt.det = TPC_DET_IDLE;
    endcase
    // completions on adjacent edges would merge into a wide pulse, so the later one waits;
    // a third in a row is folded into the second
    done_ev         = s_nxt.done || s_r.done_hold;
    s_nxt.done      = done_ev && !s_r.done;
    s_nxt.done_hold = done_ev && s_r.done;
    // manual aligner slip count wraps 9 -> 0
    if (rxd_s || !manual_align)
      s_nxt.slip = '0;
    else if (slip_s && !s_r.slip_prev)
      s_nxt.slip = (s_r.slip == `TPC_SLIP_MAX) ? 4'h0 : s_r.slip + 4'h1;
    s_nxt.word    = inv_s ? ~rx_word_in : rx_word_in;
    s_nxt.valid   = rx_word_valid && !rxd_s && !pd_s;
    s_nxt.negdisp = cmp_s;
    s_nxt.fifo_err = rx_fifo_full || rx_fifo_empty;
    s_nxt.sigdet  = above_threshold && sigdet_enable && !pd_s;
    s_nxt.idle    = idle_infer_enable ? idle_inferred : !s_nxt.sigdet;
    // status priority: detection result, then errors, then elastic buffer events
    if (s_r.det == TPC_DET_DONE && far_receiver_present)
      s_nxt.status = `TPC_ST_RX_DET;
    else if (disparity_error)
      s_nxt.status = `TPC_ST_DISP_ERR;
    else if (decode_error)
      s_nxt.status = `TPC_ST_DEC_ERR;
    else if (buf_overflow)
      s_nxt.status = `TPC_ST_OVFL;
    else if (buf_underflow)
      s_nxt.status = `TPC_ST_UNFL;
    else if (skip_added)
      s_nxt.status = `TPC_ST_SKP_ADD;
    else if (skip_removed)
      s_nxt.status = `TPC_ST_SKP_DEL;
    else
      s_nxt.status = `TPC_ST_OK;
    // verifier flags: receive reset or power-down clears both; in prbs mode a pattern cycle end also clears the error
    if (rxd_s || pd_s)
    begin
      s_nxt.bdone    = 1'b0;
      s_nxt.berr     = 1'b0;
      s_nxt.berr_cnt = '0;
    end
    else
    begin
      if (pattern_cycle_done || (bist_mode && pattern_error))
        s_nxt.bdone = 1'b1;
      if (bist_mode)
      begin
        if (pattern_error)
          s_nxt.berr = 1'b1;
      end
      else if (prbs_mode)
      begin
        if (pattern_error)
        begin
          s_nxt.berr     = 1'b1;
          s_nxt.berr_cnt = `TPC_PRBS_ERR_CYC - 3'h1;
        end
        else if (s_r.berr_cnt != 3'h0)
          s_nxt.berr_cnt = s_r.berr_cnt - 3'h1;
        else if (pattern_cycle_done)
          s_nxt.berr = 1'b0;
      end
    end
    if (pd_s)
    begin
      s_nxt.det    = TPC_DET_IDLE;
      s_nxt.done   = 1'b0;
      s_nxt.done_hold = 1'b0;
      s_nxt.slip   = '0;
      s_nxt.status = `TPC_ST_OK;
    end
  end
  always_ff @(posedge clock)
  begin
    if (reset)
    begin
      s_r          <= '0;
      s_r.det      <= TPC_DET_IDLE;
      s_r.idle     <= 1'b1;
    end
    else
      s_r <= s_nxt;
  end
  assign decoder_word            = s_r.word;
  assign encoder_negdisp         = s_r.negdisp;
  assign rx_fifo_error           = s_r.fifo_err;
  assign aligner_slip_count      = s_r.slip;
  assign lock_to_data_state      = s_r.ltd;
  assign lock_to_reference_state = ~s_r.ltd;
  assign signal_detect           = s_r.sigdet;
  assign reverse_loopback        = s_r.loopback;
  assign rx_valid                = s_r.valid;
  assign phy_done                = s_r.done;
  assign elec_idle               = s_r.idle;
  assign rx_status               = s_r.status;
  assign pll_in_reset            = pllr_s | pd_s;
  assign pll_locked              = s_r.pll_lock;
  // the minimum width of these resets is the controller's duty; tx and analog pass straight through, rx digital via the synchroniser
  assign tx_pcs_in_reset         = tx_digital_reset | pd_s;
  assign rx_pcs_in_reset         = rxd_s | pd_s;
  assign rx_pma_in_reset         = rx_analog_reset | pd_s;
  assign verifier_done           = s_r.bdone;
  assign verifier_error          = s_r.berr;
endmodule // tpc_ctrl

// ---- tb/tpc_mac_model.sv ----
// far-side controller model driving the detect and compliance controls
`timescale 1ns/1ps
module tpc_mac_model (
  input  wire logic clock,
  input  wire logic req_detect,
  input  wire logic req_loop,
  input  wire logic req_comp,
  input  wire logic phy_done,
  output logic      detect_loop,
  output logic      compliance_negdisp_force
);
  logic det_on_r;
  initial
  begin
    det_on_r = 1'b0;
    compliance_negdisp_force = 1'b0;
  end
  // the detect latch and compliance control move by non-blocking update on the rising edge, so the bench's falling-edge
  // requests and the block's registered completion are both taken without a race
  always @(posedge clock)
  begin
    if (req_detect)
      det_on_r <= 1'b1;
    else if (phy_done)
      det_on_r <= 1'b0;
    compliance_negdisp_force <= req_comp;
  end
  assign detect_loop = det_on_r | req_loop;
endmodule // tpc_mac_model

// ---- tb/tpc_ctrl_monitor.sv ----
// concurrent checks on the channel control block ports
`timescale 1ns/1ps
module tpc_ctrl_monitor (
  input wire logic       clock,
  input wire logic       reset,
  input wire logic       power_down,
  input wire logic       pll_reset,
  input wire logic       rx_digital_reset,
  input wire logic       force_lock_data,
  input wire logic       force_lock_ref,
  input wire logic       rx_analog_reset,
  input wire logic       rx_pcs_in_reset,
  input wire logic       rx_fifo_full,
  input wire logic       rx_fifo_empty,
  input wire logic       idle_infer_enable,
  input wire logic       idle_inferred,
  input wire logic       bist_mode,
  input wire logic       prbs_mode,
  input wire logic       rx_fifo_error,
  input wire logic       lock_to_data_state,
  input wire logic       lock_to_reference_state,
  input wire logic       phy_done,
  input wire logic       elec_idle,
  input wire logic       pll_in_reset,
  input wire logic       pll_locked,
  input wire logic       verifier_done,
  input wire logic       verifier_error
);
  logic [2:0] clr_hist_r;
  logic       quiet;
  // a clear still crossing the synchroniser may drop the verifier flags, so skip those cycles
  always_ff @(posedge clock)
    if (reset)
      clr_hist_r <= 3'h7;
    else
      clr_hist_r <= {clr_hist_r[1:0], rx_digital_reset | power_down};
  assign quiet = (clr_hist_r == 3'h0) && !rx_digital_reset && !power_down;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  property p_fifo_err;
    (rx_fifo_full || rx_fifo_empty) && !power_down |=> rx_fifo_error;
  endproperty
  a_fifo_err: assert property (p_fifo_err) else $error("fifo error flag missing");
  property p_lock_pair;
    lock_to_reference_state != lock_to_data_state;
  endproperty
  a_lock_pair: assert property (p_lock_pair) else $error("lock states agree");
  property p_force_data;
    (force_lock_data && !power_down && !rx_analog_reset) [*5] |-> lock_to_data_state;
  endproperty
  a_force_data: assert property (p_force_data) else $error("forced data lock ignored");
  property p_force_ref;
    (force_lock_ref && !force_lock_data && !power_down) [*5] |-> lock_to_reference_state;
  endproperty
  a_force_ref: assert property (p_force_ref) else $error("forced reference lock ignored");
  property p_pd_hold;
    power_down [*4] |-> pll_in_reset && rx_pcs_in_reset && lock_to_reference_state && !verifier_done;
  endproperty
  a_pd_hold: assert property (p_pd_hold) else $error("power-down not applied");
  property p_done_pulse;
    phy_done |=> !phy_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done wider than one cycle");
  property p_idle_infer;
    idle_infer_enable && idle_inferred && !power_down |=> elec_idle;
  endproperty
  a_idle_infer: assert property (p_idle_infer) else $error("inferred idle not shown");
  property p_pll_hold;
    pll_reset [*4] |-> pll_in_reset ##1 !pll_locked;
  endproperty
  a_pll_hold: assert property (p_pll_hold) else $error("pll not held in reset");
  property p_bist_hold;
    bist_mode && verifier_error && quiet |=> verifier_error;
  endproperty
  a_bist_hold: assert property (p_bist_hold) else $error("self-test error dropped");
  property p_vdone_hold;
    verifier_done && quiet |=> verifier_done;
  endproperty
  a_vdone_hold: assert property (p_vdone_hold) else $error("verifier done dropped");
  property p_prbs_min;
    prbs_mode && quiet && $rose(verifier_error) |=> verifier_error [*2];
  endproperty
  a_prbs_min: assert property (p_prbs_min) else $error("prbs error too short");
endmodule // tpc_ctrl_monitor
bind tpc_ctrl tpc_ctrl_monitor u_mon (.*);

// ---- tb/tpc_ctrl_tb.sv ----
// self-checking bench for the channel control block
`timescale 1ns/1ps
`include "tpc_map.svh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected t=%0t got %0h exp %0h", $time, (a), (e)); end end
module tpc_ctrl_tb;
  typedef struct packed {logic [10:0] i; logic [5:0] e;} tpc_row_t;
  logic clock, reset, power_down, pll_reset, tx_digital_reset, rx_digital_reset, rx_analog_reset;
  logic force_lock_data, force_lock_ref, cdr_freq_ok, force_elec_idle, detect_loop;
  logic far_receiver_present, compliance_negdisp_force, decoder_input_invert, rx_word_valid;
  logic rx_fifo_full, rx_fifo_empty, manual_align, slip_request, above_threshold, sigdet_enable;
  logic idle_infer_enable, idle_inferred, skip_added, skip_removed, decode_error, buf_overflow;
  logic buf_underflow, disparity_error, bist_mode, prbs_mode, pattern_cycle_done, pattern_error;
  logic encoder_negdisp, rx_fifo_error, lock_to_data_state, lock_to_reference_state;
  logic signal_detect, reverse_loopback, rx_valid, phy_done, elec_idle, pll_in_reset, pll_locked;
  logic tx_pcs_in_reset, rx_pcs_in_reset, rx_pma_in_reset, verifier_done, verifier_error;
  logic req_detect, req_loop, req_comp;
  logic [1:0] power_state;
  logic [9:0] rx_word_in, decoder_word;
  logic [3:0] aligner_slip_count;
  logic [2:0] rx_status;
  int         bad_count, checks_done;
  // status inputs {full, empty, threshold, infer on, inferred, skip+, skip-, dec, ovf, unf, disp}
  // expect {fifo error, signal detect, idle, status}
  tpc_row_t   rows [12] = '{'{11'h000, 6'h08}, '{11'h400, 6'h28}, '{11'h200, 6'h28},
    '{11'h100, 6'h10}, '{11'h1C0, 6'h18}, '{11'h080, 6'h00}, '{11'h020, 6'h09},
    '{11'h010, 6'h0A}, '{11'h008, 6'h0C}, '{11'h004, 6'h0D}, '{11'h002, 6'h0E}, '{11'h001, 6'h0F}};
  tpc_ctrl #(.PLL_LOCK_CYC(8), .DET_CYC(4)) dut (.*);
  tpc_mac_model u_mac (.clock(clock), .req_detect(req_detect), .req_loop(req_loop),
    .req_comp(req_comp), .phy_done(phy_done), .detect_loop(detect_loop),
    .compliance_negdisp_force(compliance_negdisp_force));
  always #2.5 clock = ~clock;
  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic set_row(logic [10:0] v);
    {rx_fifo_full, rx_fifo_empty, above_threshold, idle_infer_enable, idle_inferred, skip_added,
     skip_removed, decode_error, buf_overflow, buf_underflow, disparity_error} = v;
  endtask
  task automatic wait_done(int n);
    int k;
    // step off first, so a pulse still standing from the previous wait is not taken again
    @(negedge clock);
    for (k = 0; k < n && phy_done !== 1'b1; k++)
      @(negedge clock);
    if (k == n)
    begin
      bad_count++;
      $display("unexpected t=%0t no completion", $time);
      close_out();
    end
  endtask
  initial
  begin
    int  i;
    logic seen;
    {clock, power_down, pll_reset, tx_digital_reset, rx_digital_reset, rx_analog_reset,
     force_lock_data, force_lock_ref, cdr_freq_ok, force_elec_idle, far_receiver_present,
     decoder_input_invert, rx_word_valid, manual_align, slip_request, sigdet_enable, bist_mode,
     prbs_mode, pattern_cycle_done, pattern_error, req_detect, req_loop, req_comp} = '0;
    set_row(11'h000);
    {power_state, rx_word_in, bad_count, checks_done} = '0;
    reset = 1'b1;
    cyc(2);
    reset = 1'b0;
    cyc(1);
    `CHK(lock_to_reference_state, 1'b1);
    sigdet_enable = 1'b1;
    foreach (rows[k])
    begin
      set_row(rows[k].i);
      cyc(5);
      `CHK(rx_fifo_error, rows[k].e[5]);
      `CHK(signal_detect, rows[k].e[4]);
      `CHK(elec_idle, rows[k].e[3]);
      `CHK(rx_status, rows[k].e[2:0]);
    end
    set_row(11'h000);
    pll_reset = 1'b1;
    cyc(5);
    `CHK(pll_locked, 1'b0);
    pll_reset = 1'b0;
    cyc(14);
    `CHK(pll_locked, 1'b1);
    cdr_freq_ok = 1'b1;
    for (i = 0; i < 4; i++)
    begin
      {force_lock_data, force_lock_ref} = i[1:0];
      cyc(5);
      `CHK(lock_to_data_state, 1'(i != 1));
    end
    {force_lock_data, force_lock_ref} = 2'h0;
    for (i = 1; i < 5; i++)
    begin
      power_state = 2'((i * 3) % 4);
      wait_done(10);
      cyc(1);
      `CHK(phy_done, 1'b0);
    end
    power_state = `TPC_PWR_P1;
    wait_done(10);
    {force_elec_idle, far_receiver_present} = 2'h3;
    cyc(4);
    req_detect = 1'b1;
    cyc(1);
    req_detect = 1'b0;
    wait_done(30);
    `CHK(rx_status, `TPC_ST_RX_DET);
    `CHK(reverse_loopback, 1'b0);
    power_state = `TPC_PWR_P0;
    wait_done(10);
    force_elec_idle = 1'b0;
    req_loop = 1'b1;
    cyc(5);
    `CHK(reverse_loopback, 1'b1);
    req_loop = 1'b0;
    req_comp = 1'b1;
    cyc(1);
    req_comp = 1'b0;
    seen = 1'b0;
    repeat (6)
    begin
      cyc(1);
      seen = seen | (encoder_negdisp === 1'b1);
    end
    `CHK(seen, 1'b1);
    {rx_word_in, rx_word_valid} = {10'h2A5, 1'b1};
    for (i = 0; i < 2; i++)
    begin
      decoder_input_invert = i[0];
      cyc(5);
      `CHK(decoder_word, i ? 10'h15A : 10'h2A5);
      `CHK(rx_valid, 1'b1);
    end
    manual_align = 1'b1;
    for (i = 1; i < 11; i++)
    begin
      slip_request = 1'b1;
      cyc(3);
      slip_request = 1'b0;
      cyc(3);
      if (i > 8)
        `CHK(aligner_slip_count, (i == 9) ? `TPC_SLIP_MAX : 4'h0);
    end
    bist_mode = 1'b1;
    pattern_error = 1'b1;
    cyc(1);
    pattern_error = 1'b0;
    cyc(8);
    `CHK(verifier_error, 1'b1);
    `CHK(verifier_done, 1'b1);
    rx_digital_reset = 1'b1;
    cyc(4);
    `CHK(rx_pcs_in_reset, 1'b1);
    rx_digital_reset = 1'b0;
    cyc(5);
    `CHK(verifier_error, 1'b0);
    `CHK(verifier_done, 1'b0);
    {bist_mode, prbs_mode, pattern_error} = 3'h3;
    cyc(1);
    pattern_error = 1'b0;
    for (i = 0; i < 8 && verifier_error !== 1'b1; i++)
      cyc(1);
    if (i == 8)
    begin
      bad_count++;
      $display("unexpected t=%0t no verifier error", $time);
      close_out();
    end
    cyc(2);
    `CHK(verifier_error, 1'b1);
    pattern_cycle_done = 1'b1;
    cyc(1);
    pattern_cycle_done = 1'b0;
    cyc(8);
    `CHK(verifier_error, 1'b0);
    `CHK(verifier_done, 1'b1);
    {tx_digital_reset, rx_analog_reset} = 2'h3;
    cyc(2);
    `CHK(tx_pcs_in_reset, 1'b1);
    `CHK(rx_pma_in_reset, 1'b1);
    {tx_digital_reset, rx_analog_reset} = 2'h0;
    power_down = 1'b1;
    cyc(5);
    `CHK({rx_pcs_in_reset, pll_in_reset, lock_to_reference_state}, 3'h7);
    power_down = 1'b0;
    cyc(5);
    `CHK(verifier_done, 1'b0);
    close_out();
  end
endmodule // tpc_ctrl_tb
